// ---- verilog/vtr_top.sv ----
// Vector table relocation control with APB register access
// Function
// - Select zero puts vectors at flash start, select one at the boot section start.
// - The boot section start comes from the boot size fuses.
// - Interrupts are blocked from the arming cycle until after the instruction after the select write.
// - If select is not written after arming, blocking lasts four cycles then ends.
// - The automatic blocking leaves the global interrupt enable flag alone.
// - Change enable clears four cycles after being set or at once when select is written.
// - Boot vectors with application lock programmed block interrupts in the application section.
// - Application vectors with boot lock programmed block interrupts in the boot section.
// - Fuse unprogrammed, 2K boot, select set gives reset 0x000 and vectors 0xc01 to 0xc14.
// - Fuse programmed, 2K boot, select clear gives reset 0xc00 and vectors 0x001 to 0x014.
// - Fuse programmed, 2K boot, select set gives reset 0xc00 and vectors from 0xc01.
// - Fuse one fetches reset at word zero, fuse zero at the boot reset address.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module vtr_top
  import vtr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_select_fuse,
  input wire logic application_side_lock_bit,
  input wire logic boot_side_lock_bit,
  input wire logic exec_in_boot,
  output logic irq_block,
  output logic external_irq_zero_enable,
  output logic external_irq_one_enable,
  output logic external_irq_two_enable,
  output logic [11:0] reset_addr,
  output logic [11:0] vec_first,
  output logic [11:0] vec_last
);
  import vtr_pkg::*;

  // ****************************************
  // Decode helper
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == GIC_OFF);
  endfunction : reg_hit

  // ****************************************
  // State
  // ****************************************
  logic sel_r;
  logic sel_nxt;
  logic arm_r;
  logic arm_nxt;
  logic [2:0] arm_cnt_r;
  logic [2:0] arm_cnt_nxt;
  logic post_r;
  logic post_nxt;
  logic [2:0] post_cnt_r;
  logic [2:0] post_cnt_nxt;
  logic [2:0] ext_en_r;
  logic [2:0] ext_en_nxt;
  logic block_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [11:0] reset_addr_r;
  logic [11:0] vec_first_r;
  logic [11:0] vec_last_r;

  wire [11:0] loc_reset;
  wire [11:0] loc_first;
  wire [11:0] loc_last;
  wire setup_ph;
  wire access_done;
  wire hit;
  wire wr_ok;
  wire lane0;
  wire wr_ce;
  wire wr_sel_val;
  wire do_arm;
  wire do_commit;
  wire arm_expire;
  wire post_expire;
  wire lock_dis;
  wire block_nxt;
  wire [7:0] gic_view;

  // ****************************************
  // APB decode
  // ****************************************
  assign setup_ph = psel & ~penable;
  assign access_done = psel & penable & pready_r;
  assign hit = reg_hit(paddr);
  assign lane0 = pstrb[0];
  assign wr_ok = access_done & pwrite & hit & lane0;
  assign wr_ce = pwdata[BIT_CE];
  assign wr_sel_val = pwdata[BIT_SEL];
  assign gic_view = {ext_en_r[1], ext_en_r[0], ext_en_r[2], 3'h0, sel_r, arm_r};

  // ****************************************
  // Change sequence
  // ****************************************
  assign do_arm = wr_ok & wr_ce;
  assign do_commit = wr_ok & ~wr_ce & arm_r;
  assign arm_expire = arm_r & (arm_cnt_r == 3'h0);
  assign post_expire = post_r & (post_cnt_r == 3'h0);

  always_comb
  begin
    sel_nxt = sel_r;
    if (do_commit)
    begin
      sel_nxt = wr_sel_val;
    end
  end

  always_comb
  begin
    arm_nxt = arm_r;
    arm_cnt_nxt = arm_cnt_r;
    if (do_arm)
    begin
      arm_nxt = 1'b1;
      arm_cnt_nxt = CE_LOAD;
    end
    else if (do_commit || arm_expire)
    begin
      arm_nxt = 1'b0;
      arm_cnt_nxt = 3'h0;
    end
    else if (arm_r)
    begin
      arm_cnt_nxt = arm_cnt_r - 3'h1;
    end
  end

  always_comb
  begin
    post_nxt = post_r;
    post_cnt_nxt = post_cnt_r;
    if (do_commit)
    begin
      post_nxt = 1'b1;
      post_cnt_nxt = POST_LOAD;
    end
    else if (post_expire)
    begin
      post_nxt = 1'b0;
      post_cnt_nxt = 3'h0;
    end
    else if (post_r)
    begin
      post_cnt_nxt = post_cnt_r - 3'h1;
    end
  end

  // ****************************************
  // External enables
  // ****************************************
  function automatic int unsigned ext_pos(input int unsigned idx);
    case (idx)
      0: ext_pos = BIT_IRQ0_EN;
      1: ext_pos = BIT_IRQ1_EN;
      default: ext_pos = BIT_IRQ2_EN;
    endcase
  endfunction : ext_pos

  for (genvar g = 0; g < 3; g++)
  begin : g_ext_en
    assign ext_en_nxt[g] = wr_ok ? pwdata[ext_pos(g)] : ext_en_r[g];
  end

  // ****************************************
  // Lock based disabling
  // ****************************************
  assign lock_dis = (sel_r & ~application_side_lock_bit & ~exec_in_boot)
                  | (~sel_r & ~boot_side_lock_bit & exec_in_boot);
  assign block_nxt = arm_nxt | post_nxt | lock_dis;

  // ****************************************
  // Placement lookup
  // ****************************************
  vtr_locator u_loc (
    .boot_size_fuses(boot_size_fuses),
    .boot_reset_select_fuse(boot_reset_select_fuse),
    .vector_table_select(sel_r),
    .reset_addr(loc_reset),
    .vec_first(loc_first),
    .vec_last(loc_last)
  );

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sel_r <= GIC_RESET[BIT_SEL];
      arm_r <= GIC_RESET[BIT_CE];
      arm_cnt_r <= 3'h0;
    end
    else
    begin
      sel_r <= sel_nxt;
      arm_r <= arm_nxt;
      arm_cnt_r <= arm_cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      post_r <= 1'b0;
      post_cnt_r <= 3'h0;
    end
    else
    begin
      post_r <= post_nxt;
      post_cnt_r <= post_cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ext_en_r <= 3'h0;
    end
    else
    begin
      ext_en_r <= ext_en_nxt;
    end
  end

  // Blocking only gates delivery, no global flag is touched
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      block_r <= 1'b0;
    end
    else
    begin
      block_r <= block_nxt;
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end
    else
    begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & ~hit;
      prdata_r <= (setup_ph & hit & ~pwrite) ? {24'h0, gic_view} : 32'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reset_addr_r <= RESET_APP;
      vec_first_r <= VEC_FIRST_OFS;
      vec_last_r <= VEC_LAST_OFS;
    end
    else
    begin
      reset_addr_r <= loc_reset;
      vec_first_r <= loc_first;
      vec_last_r <= loc_last;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_block = block_r;
  assign external_irq_zero_enable = ext_en_r[0];
  assign external_irq_one_enable = ext_en_r[1];
  assign external_irq_two_enable = ext_en_r[2];
  assign reset_addr = reset_addr_r;
  assign vec_first = vec_first_r;
  assign vec_last = vec_last_r;
endmodule : vtr_top

// ---- verilog/vtr_pkg.sv ----
// Constants for the vector table relocation block
package vtr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] GIC_OFF = 8'h00;
  localparam logic [7:0] GIC_RESET = 8'h00;
  localparam int unsigned BIT_IRQ1_EN = 7;
  localparam int unsigned BIT_IRQ0_EN = 6;
  localparam int unsigned BIT_IRQ2_EN = 5;
  localparam int unsigned BIT_SEL = 1;
  localparam int unsigned BIT_CE = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CE_WINDOW_CYC = 4;
  localparam int unsigned POST_BLOCK_CYC = 2;
  localparam logic [2:0] CE_LOAD = 3'(CE_WINDOW_CYC - 1);
  localparam logic [2:0] POST_LOAD = 3'(POST_BLOCK_CYC - 1);
  // ****************************************
  // Program memory word addresses
  // ****************************************
  localparam logic [11:0] RESET_APP = 12'h000;
  localparam logic [11:0] VEC_FIRST_OFS = 12'h001;
  localparam logic [11:0] VEC_LAST_OFS = 12'h014;
  localparam logic [11:0] BOOT_START_SZ0 = 12'hc00;
  localparam logic [11:0] BOOT_START_SZ1 = 12'he00;
  localparam logic [11:0] BOOT_START_SZ2 = 12'hf00;
  localparam logic [11:0] BOOT_START_SZ3 = 12'hf80;
endpackage : vtr_pkg

// ---- verilog/vtr_locator.sv ----
// Vector and reset address locator
`timescale 1ns/1ps
module vtr_locator
  import vtr_pkg::*;
(
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_select_fuse,
  input wire logic vector_table_select,
  output logic [11:0] reset_addr,
  output logic [11:0] vec_first,
  output logic [11:0] vec_last
);
  import vtr_pkg::*;

  wire [11:0] boot_start;

  // ****************************************
  // Boot section start from size fuses
  // ****************************************
  assign boot_start = (boot_size_fuses == 2'h0) ? BOOT_START_SZ0 :
                      (boot_size_fuses == 2'h1) ? BOOT_START_SZ1 :
                      (boot_size_fuses == 2'h2) ? BOOT_START_SZ2 :
                      BOOT_START_SZ3;

  // ****************************************
  // Placement
  // ****************************************
  assign reset_addr = boot_reset_select_fuse ? RESET_APP : boot_start;
  assign vec_first = vector_table_select ? boot_start + VEC_FIRST_OFS
                                         : VEC_FIRST_OFS;
  assign vec_last = vector_table_select ? boot_start + VEC_LAST_OFS
                                        : VEC_LAST_OFS;
endmodule : vtr_locator

// ---- tb/vtr_sva.sv ----
// Checker for the vector table relocation block
`timescale 1ns/1ps
module vtr_sva
  import vtr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_select_fuse,
  input wire logic application_side_lock_bit,
  input wire logic boot_side_lock_bit,
  input wire logic irq_block,
  input wire logic exec_in_boot,
  input wire logic [11:0] reset_addr,
  input wire logic [11:0] vec_first,
  input wire logic [11:0] vec_last
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire acc = psel && penable && pready && pwrite && paddr == 8'h00 && pstrb[0];
  wire arm = acc && pwdata[0];
  wire put = acc && !pwdata[0];
  wire nolk = application_side_lock_bit && boot_side_lock_bit;
  a_err_unmapped: assert property (pready |-> pslverr == (paddr != 8'h00))
    else $error("pslverr wrong");
  a_vec_span: assert property (vec_last == vec_first + 12'h013)
    else $error("vector span wrong");
  a_boot_reset: assert property (!boot_reset_select_fuse && boot_size_fuses == 2'h0
    && $stable(boot_size_fuses) |=> reset_addr == 12'hc00) else $error("boot reset word wrong");
  a_arm_block: assert property (arm |=> irq_block [*3])
    else $error("no block after arming");
  a_arm_expire: assert property (arm ##1 (!psel && nolk) [*4] |=> !irq_block)
    else $error("block did not end");
  a_put_release: assert property (arm ##2 put ##1 (!psel && nolk) [*3] |=> !irq_block)
    else $error("block after commit too long");
  a_move_boot: assert property (arm ##2 (put && pwdata[1] && boot_size_fuses == 2'h0)
    |-> ##3 vec_first == 12'hc01) else $error("vectors not moved");
  a_lock_app: assert property ($stable(vec_first) && vec_first != 12'h001
    && !application_side_lock_bit && !exec_in_boot |=> irq_block) else $error("app lock");
  a_lock_boot: assert property ($stable(vec_first) && vec_first == 12'h001
    && !boot_side_lock_bit && exec_in_boot |=> irq_block) else $error("boot lock");
  cover property (arm ##2 put);
  cover property (pready && pslverr);
  cover property (arm ##5 !irq_block);
endmodule : vtr_sva
bind vtr_top vtr_sva i_sva (.*);

// ---- tb/vtr_top_test.sv ----
// Self-checking bench for the vector table relocation block
`timescale 1ns/1ps
module vtr_top_test;
  import vtr_pkg::*;
  // ********
  // Bench
  // ********
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] boot_size_fuses = 2'h0;
  logic boot_reset_select_fuse = 1'b1;
  logic application_side_lock_bit = 1'b1;
  logic boot_side_lock_bit = 1'b1;
  logic exec_in_boot = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, err, irq_block;
  logic external_irq_zero_enable, external_irq_one_enable, external_irq_two_enable;
  logic [11:0] reset_addr, vec_first, vec_last;
  logic [11:0] bs [4] = '{BOOT_START_SZ0, BOOT_START_SZ1, BOOT_START_SZ2, BOOT_START_SZ3};
  int mismatches = 0;
  int n_checks = 0;
  vtr_top i_dut (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
  endtask : acc
  task idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : idle
  task rd(input logic [7:0] a);
    acc(1'b0, a, 32'h0);
    idle();
  endtask : rd
  task move(input logic s);
    acc(1'b1, 8'h00, 32'h1);
    acc(1'b1, 8'h00, {30'h0, s, 1'b0});
    idle();
  endtask : move
  task tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(8'h00);
    chk("reg", 32'h0, rdat);
    chk("reset word", 32'h0, 32'(reset_addr));
    chk("first vec", 32'h001, 32'(vec_first));
    chk("last vec", 32'h014, 32'(vec_last));
    acc(1'b1, 8'h04, 32'h1);
    idle();
    chk("err", 32'h1, 32'(err));
    rd(8'h04);
    chk("err", 32'h1, 32'(err));
    chk("unmapped", 32'h0, rdat);
    chk("block", 32'h0, 32'(irq_block));
    $display("test reset and unmapped done");
    acc(1'b1, 8'h00, 32'hfe);
    idle();
    pstrb <= 4'he;
    acc(1'b1, 8'h00, 32'h0);
    idle();
    pstrb <= 4'hf;
    rd(8'h00);
    chk("reg", 32'he0, rdat);
    chk("enables", 32'h7, 32'({external_irq_one_enable, external_irq_zero_enable,
      external_irq_two_enable}));
    chk("first vec", 32'h001, 32'(vec_first));
    acc(1'b1, 8'h00, 32'h42);
    idle();
    rd(8'h00);
    chk("reg", 32'h40, rdat);
    chk("enables", 32'h2, 32'({external_irq_one_enable, external_irq_zero_enable,
      external_irq_two_enable}));
    $display("test unarmed write done");
    acc(1'b1, 8'h00, 32'h1);
    idle();
    chk("block", 32'h1, 32'(irq_block));
    repeat (3) @(posedge clk_sys);
    chk("block", 32'h1, 32'(irq_block));
    @(posedge clk_sys);
    chk("block", 32'h0, 32'(irq_block));
    rd(8'h00);
    chk("reg", 32'h0, rdat);
    acc(1'b1, 8'h00, 32'h1);
    idle();
    rd(8'h00);
    chk("reg", 32'h1, rdat);
    $display("test expiry done");
    move(1'b1);
    chk("block", 32'h1, 32'(irq_block));
    rd(8'h00);
    chk("reg", 32'h2, rdat);
    chk("first vec", 32'hc01, 32'(vec_first));
    chk("last vec", 32'hc14, 32'(vec_last));
    chk("reset word", 32'h0, 32'(reset_addr));
    boot_reset_select_fuse <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      boot_size_fuses <= 2'(i);
      repeat (3) @(posedge clk_sys);
      chk("reset word", 32'(bs[i]), 32'(reset_addr));
      chk("first vec", 32'(bs[i] + 12'h001), 32'(vec_first));
    end
    boot_size_fuses <= 2'h0;
    move(1'b0);
    repeat (3) @(posedge clk_sys);
    chk("reset word", 32'hc00, 32'(reset_addr));
    chk("first vec", 32'h001, 32'(vec_first));
    chk("last vec", 32'h014, 32'(vec_last));
    $display("test placement done");
    boot_side_lock_bit <= 1'b0;
    exec_in_boot <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("block", 32'h1, 32'(irq_block));
    exec_in_boot <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("block", 32'h0, 32'(irq_block));
    boot_side_lock_bit <= 1'b1;
    move(1'b1);
    application_side_lock_bit <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk("block", 32'h1, 32'(irq_block));
    exec_in_boot <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("block", 32'h0, 32'(irq_block));
    $display("test locks done");
    tally_and_finish();
  end
endmodule : vtr_top_test
